/* File: inc/dea_pkg.sv */
// Package: data EEPROM access control constants and types
package dea_pkg;
  // Special function register locations
  localparam logic [7:0] SFR_CTRL = 8'h96;
  localparam logic [7:0] SFR_DPA_LO = 8'h82;
  localparam logic [7:0] SFR_DPA_HI = 8'h83;
  localparam logic [7:0] SFR_DPB_LO = 8'h84;
  localparam logic [7:0] SFR_DPB_HI = 8'h85;
  // Control register bit positions
  localparam int BIT_LOAD = 5;
  localparam int BIT_WREN = 4;
  localparam int BIT_ISEL = 3;
  localparam int BIT_BANK = 2;
  localparam int BIT_RDY = 1;
  localparam int BIT_WINH = 0;
  // Writable bits and reset value (ready, not inhibited)
  localparam logic [7:0] CTRL_WMASK = 8'h3C;
  localparam logic [7:0] CTRL_RESET = 8'h03;
  // Array geometry
  localparam int EE_BYTES = 2048;
  localparam int EE_AW = 11;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_AW = 5;
  // Programming time
  localparam int PROG_TIME_US = 4000;
  localparam int CLK_MHZ = 200;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam logic [15:0] EE_LIMIT = 16'h0800;

  // External data move request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] wdata;
  } dea_xreq_t;

  // SFR access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dea_sfr_t;

  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_COMMIT} dea_state_t;
endpackage

/* File: rtl/dea_page_buf.sv */
// Page buffer: volatile byte store with per-byte loaded marks
`timescale 1ns/1ps
module dea_page_buf #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Load port
  input wire logic ld_en,
  input wire logic [AW-1:0] ld_idx,
  input wire logic [7:0] ld_data,
  // Clear all marks
  input wire logic clr,
  // Read port
  input wire logic [AW-1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic rd_mark
);
  logic [7:0] data_reg [DEPTH];
  logic [DEPTH-1:0] mark_reg;
  logic [DEPTH-1:0] mark_next;

  always_comb begin
    mark_next = mark_reg;
    if (clr) begin
      mark_next = '0;
    end
    if (ld_en) begin
      mark_next[ld_idx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mark_reg <= '0;
    end else begin
      mark_reg <= mark_next;
    end
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_byte
      always_ff @(posedge core_clk) begin
        if (ld_en && ld_idx == AW'(i)) begin
          data_reg[i] <= ld_data;
        end
      end
    end
  endgenerate

  assign rd_data = data_reg[rd_idx];
  assign rd_mark = mark_reg[rd_idx];
endmodule

/* File: rtl/dea_ctrl.sv */
// Data EEPROM access control: SFRs, pointer banks, page write, array
`timescale 1ns/1ps
module dea_ctrl
  import dea_pkg::*;
#(
  parameter int PROG_CNT = PROG_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // SFR port
  input dea_pkg::dea_sfr_t sfr,
  output logic [7:0] sfr_rdata,
  // External data move port
  input dea_pkg::dea_xreq_t xreq,
  output logic [7:0] xrdata,
  output logic xdone,
  // External data memory
  output logic ext_sel,
  output logic [15:0] ext_addr,
  // Supply monitor
  input wire logic supply_low
);
  import dea_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] ctrl_reg, ctrl_next;
  logic [15:0] dpa_reg, dpa_next, dpb_reg, dpb_next;
  logic [7:0] ee_reg [EE_BYTES];
  dea_state_t st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [EE_AW-PAGE_AW-1:0] page_reg, page_next;
  logic [PAGE_AW-1:0] idx_reg, idx_next;
  logic [7:0] last_reg, last_next;
  logic [EE_AW-1:0] last_addr_reg, last_addr_next;
  logic [7:0] sfr_rdata_reg, sfr_rdata_next;
  logic [7:0] xrdata_reg, xrdata_next;
  logic xdone_reg, ext_sel_reg, ext_sel_next;
  logic [15:0] ext_addr_reg, ext_addr_next;

  // ************************************************************
  // Decode
  // ************************************************************
  logic [15:0] data_pointer_reg;
  logic internal, ee_wr, busy, inhibit;
  logic ld_en, pb_clr;
  logic [7:0] pb_data;
  logic pb_mark;

  assign data_pointer_reg = ctrl_reg[BIT_BANK] ? dpb_reg : dpa_reg;
  assign internal = ctrl_reg[BIT_ISEL] && (data_pointer_reg < EE_LIMIT);
  assign busy = (st_reg != ST_IDLE);
  assign inhibit = supply_low;
  // no effect without write enable; refused when inhibited
  assign ee_wr = xreq.valid && xreq.write && internal &&
                 ctrl_reg[BIT_WREN] && !inhibit && !busy;
  assign ld_en = ee_wr;

  dea_page_buf #(
    .DEPTH(PAGE_BYTES),
    .AW(PAGE_AW)
  ) i_dea_page_buf (
    .core_clk(core_clk),
    .resetn(resetn),
    .ld_en(ld_en),
    .ld_idx(data_pointer_reg[PAGE_AW-1:0]),
    .ld_data(xreq.wdata),
    .clr(pb_clr),
    .rd_idx(idx_reg),
    .rd_data(pb_data),
    .rd_mark(pb_mark)
  );

  // ************************************************************
  // SFR and pointer next state
  // ************************************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    dpa_next = dpa_reg;
    dpb_next = dpb_reg;
    sfr_rdata_next = sfr_rdata_reg;
    if (sfr.wr && sfr.addr == SFR_CTRL) begin
      ctrl_next = (ctrl_reg & ~CTRL_WMASK) | (sfr.wdata & CTRL_WMASK);
    end
    if (sfr.wr && sfr.addr == SFR_DPA_LO) dpa_next[7:0] = sfr.wdata;
    if (sfr.wr && sfr.addr == SFR_DPA_HI) dpa_next[15:8] = sfr.wdata;
    if (sfr.wr && sfr.addr == SFR_DPB_LO) dpb_next[7:0] = sfr.wdata;
    if (sfr.wr && sfr.addr == SFR_DPB_HI) dpb_next[15:8] = sfr.wdata;
    ctrl_next[BIT_RDY] = !busy && !(ee_wr && !ctrl_reg[BIT_LOAD]);
    ctrl_next[BIT_WINH] = !inhibit;
    ctrl_next[7:6] = 2'b00;
    if (sfr.rd) begin
      unique case (sfr.addr)
        SFR_CTRL: sfr_rdata_next = ctrl_reg;
        SFR_DPA_LO: sfr_rdata_next = dpa_reg[7:0];
        SFR_DPA_HI: sfr_rdata_next = dpa_reg[15:8];
        SFR_DPB_LO: sfr_rdata_next = dpb_reg[7:0];
        SFR_DPB_HI: sfr_rdata_next = dpb_reg[15:8];
        default: sfr_rdata_next = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Programming sequencer
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    page_next = page_reg;
    idx_next = idx_reg;
    last_next = last_reg;
    last_addr_next = last_addr_reg;
    pb_clr = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        if (ee_wr && !ctrl_reg[BIT_LOAD]) begin
          st_next = ST_PROG;
          cnt_next = 32'(PROG_CNT - 1);
          page_next = data_pointer_reg[EE_AW-1:PAGE_AW];
          last_next = xreq.wdata;
          last_addr_next = data_pointer_reg[EE_AW-1:0];
        end
      end
      ST_PROG: begin
        if (inhibit) begin
          st_next = ST_IDLE;
          pb_clr = 1'b1;
        end else if (cnt_reg == 32'h0000_0000) begin
          st_next = ST_COMMIT;
          idx_next = '0;
        end else begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end
      end
      ST_COMMIT: begin
        if (inhibit) begin
          st_next = ST_IDLE;
          idx_next = '0;
          pb_clr = 1'b1;
        end else begin
          idx_next = idx_reg + PAGE_AW'(1);
          if (idx_reg == PAGE_AW'(PAGE_BYTES - 1)) begin
            st_next = ST_IDLE;
            pb_clr = 1'b1;
          end
        end
      end
    endcase
  end

  // ************************************************************
  // Move read path and external routing
  // ************************************************************
  always_comb begin
    xrdata_next = xrdata_reg;
    ext_sel_next = ext_sel_reg;
    ext_addr_next = ext_addr_reg;
    if (xreq.valid) begin
      ext_sel_next = !internal;
      ext_addr_next = data_pointer_reg;
      if (!xreq.write && internal) begin
        if (busy && data_pointer_reg[EE_AW-1:0] == last_addr_reg) begin
          xrdata_next = {~last_reg[7], last_reg[6:0]};
        end else begin
          xrdata_next = ee_reg[data_pointer_reg[EE_AW-1:0]];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RESET;
      dpa_reg <= 16'h0000;
      dpb_reg <= 16'h0000;
      st_reg <= ST_IDLE;
      cnt_reg <= 32'h0000_0000;
      page_reg <= '0;
      idx_reg <= '0;
      last_reg <= 8'h00;
      last_addr_reg <= '0;
      sfr_rdata_reg <= 8'h00;
      xrdata_reg <= 8'h00;
      xdone_reg <= 1'b0;
      ext_sel_reg <= 1'b0;
      ext_addr_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      dpa_reg <= dpa_next;
      dpb_reg <= dpb_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      page_reg <= page_next;
      idx_reg <= idx_next;
      last_reg <= last_next;
      last_addr_reg <= last_addr_next;
      sfr_rdata_reg <= sfr_rdata_next;
      xrdata_reg <= xrdata_next;
      xdone_reg <= xreq.valid;
      ext_sel_reg <= ext_sel_next;
      ext_addr_reg <= ext_addr_next;
    end
  end

  // Array commit: only marked bytes of the page are rewritten
  always_ff @(posedge core_clk) begin
    if (st_reg == ST_COMMIT && pb_mark && !inhibit) begin
      ee_reg[{page_reg, idx_reg}] <= pb_data;
    end
  end

  assign sfr_rdata = sfr_rdata_reg;
  assign xrdata = xrdata_reg;
  assign xdone = xdone_reg;
  assign ext_sel = ext_sel_reg;
  assign ext_addr = ext_addr_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_load_only;
    @(posedge core_clk) disable iff (!resetn)
      (ee_wr && ctrl_reg[BIT_LOAD] && !busy) |=> st_reg == ST_IDLE;
  endproperty
  a_load_only: assert property (p_load_only)
    else $error("load started prog");

  property p_launch;
    @(posedge core_clk) disable iff (!resetn)
      (ee_wr && !ctrl_reg[BIT_LOAD]) |=> st_reg == ST_PROG;
  endproperty
  a_launch: assert property (p_launch)
    else $error("prog not launched");

  property p_route;
    @(posedge core_clk) disable iff (!resetn)
      xreq.valid |=> ext_sel == $past(!(ctrl_reg[BIT_ISEL] && data_pointer_reg < EE_LIMIT));
  endproperty
  a_route: assert property (p_route) else $error("bad routing");

  property p_bank;
    @(posedge core_clk) disable iff (!resetn)
      xreq.valid |=> ext_addr == ($past(ctrl_reg[BIT_BANK]) ?
        $past(dpb_reg) : $past(dpa_reg));
  endproperty
  a_bank: assert property (p_bank) else $error("bad bank");

  property p_ready;
    @(posedge core_clk) disable iff (!resetn)
      st_reg == ST_PROG ##1 st_reg == ST_PROG |-> !ctrl_reg[BIT_RDY];
  endproperty
  a_ready: assert property (p_ready) else $error("ready while busy");

  property p_inh;
    @(posedge core_clk) disable iff (!resetn)
      supply_low |=> !ctrl_reg[BIT_WINH] && st_reg != ST_PROG;
  endproperty
  a_inh: assert property (p_inh) else $error("inhibit ignored");

  property p_wren;
    @(posedge core_clk) disable iff (!resetn)
      (xreq.valid && xreq.write && !ctrl_reg[BIT_WREN] && !busy) |=>
        st_reg == ST_IDLE;
  endproperty
  a_wren: assert property (p_wren) else $error("write without enable");

  property p_unused;
    @(posedge core_clk) disable iff (!resetn)
      sfr.rd && sfr.addr == SFR_CTRL |=> sfr_rdata[7:6] == 2'b00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits set");

  c_prog: cover property (@(posedge core_clk) disable iff (!resetn)
    st_reg == ST_COMMIT ##1 st_reg == ST_IDLE);
  c_load: cover property (@(posedge core_clk) disable iff (!resetn)
    ee_wr && ctrl_reg[BIT_LOAD]);
  c_abort: cover property (@(posedge core_clk) disable iff (!resetn)
    st_reg == ST_PROG && inhibit);
endmodule

/* File: verification/dea_core_bfm.sv */
// Core-side model issuing SFR accesses and data moves
`timescale 1ns/1ps
module dea_core_bfm
  import dea_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Towards the block
  output dea_pkg::dea_sfr_t sfr,
  input wire logic [7:0] sfr_rdata,
  output dea_pkg::dea_xreq_t xreq,
  input wire logic [7:0] xrdata,
  input wire logic xdone
);
  initial begin
    sfr = '0;
    xreq = '0;
  end

  // One SFR write or read, answer taken the cycle after
  task automatic sfr_acc(input logic w, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    #1 sfr = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk);
    #1 sfr = '0;
    q = sfr_rdata;
  endtask

  // One data move through the active pointer
  task automatic mov(input logic w, input logic [7:0] d,
                     output logic [7:0] q, output logic dn);
    @(posedge core_clk);
    #1 xreq = '{valid: 1'b1, write: w, wdata: d};
    @(posedge core_clk);
    #1 xreq = '0;
    q = xrdata;
    dn = xdone;
  endtask
endmodule

/* File: verification/data_eeprom_access_control_tb_top.sv */
// Testbench for the data EEPROM access control block
`timescale 1ns/1ps
module data_eeprom_access_control_tb_top;
  import dea_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } dea_row_t;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic supply_low = 1'b0;
  dea_sfr_t sfr;
  dea_xreq_t xreq;
  logic [7:0] sfr_rdata;
  logic [7:0] xrdata;
  logic xdone;
  logic ext_sel;
  logic [15:0] ext_addr;
  logic [7:0] q;
  logic dn;
  int err_total = 0;
  int checked = 0;
  dea_row_t rows [7] = '{'{8'h82, 8'h10, 8'h10}, '{8'h83, 8'h00, 8'h00},
    '{8'h84, 8'h00, 8'h00}, '{8'h85, 8'h09, 8'h09},
    '{8'h96, 8'hFF, 8'h3F}, '{8'h96, 8'hC4, 8'h07},
    '{8'h90, 8'hAA, 8'h00}};

  always #2.5 core_clk = ~core_clk;

  dea_ctrl #(.PROG_CNT(20)) i_dea_ctrl (.core_clk(core_clk),
    .resetn(resetn), .sfr(sfr), .sfr_rdata(sfr_rdata), .xreq(xreq),
    .xrdata(xrdata), .xdone(xdone), .ext_sel(ext_sel),
    .ext_addr(ext_addr), .supply_low(supply_low));

  dea_core_bfm i_dea_core_bfm (.core_clk(core_clk), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .xreq(xreq), .xrdata(xrdata), .xdone(xdone));

  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_dea_core_bfm.sfr_acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    i_dea_core_bfm.sfr_acc(1'b0, a, 8'h00, q);
  endtask
  task automatic mv(input logic w, input logic [7:0] d);
    i_dea_core_bfm.mov(w, d, q, dn);
  endtask
  task automatic route(input logic [7:0] c, input logic [16:0] e);
    wr(SFR_CTRL, c);
    mv(1'b0, 8'h00);
    chk(dn, 1'b1);
    chk({ext_sel, ext_addr}, e);
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    rd(SFR_CTRL);
    while (q[BIT_RDY] !== 1'b1 && n < 200) begin
      rd(SFR_CTRL);
      n++;
    end
    chk(q[BIT_RDY], 1'b1);
  endtask
  task automatic stop_test;
    $display("Mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************
  // Watchdog
  // ****************
  initial begin
    #50000;
    err_total++;
    stop_test();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (20) @(posedge core_clk);
    #1 resetn = 1'b1;
    rd(SFR_CTRL);
    chk(q, CTRL_RESET);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(q, rows[i].e);
    end
    route(8'h08, {1'b0, 16'h0010});
    route(8'h0C, {1'b1, 16'h0900});
    route(8'h00, {1'b1, 16'h0010});
    // Single byte write and busy read
    wr(SFR_CTRL, 8'h18);
    mv(1'b1, 8'hA5);
    rd(SFR_CTRL);
    chk(q[BIT_RDY], 1'b0);
    mv(1'b0, 8'h00);
    chk(q, 8'h25);
    wait_rdy();
    mv(1'b0, 8'h00);
    chk(q, 8'hA5);
    wr(SFR_DPA_LO, 8'h11);
    mv(1'b1, 8'h3C);
    wait_rdy();
    wr(SFR_DPA_LO, 8'h10);
    mv(1'b0, 8'h00);
    chk(q, 8'hA5);
    // Write with enable clear
    wr(SFR_CTRL, 8'h08);
    mv(1'b1, 8'h5A);
    rd(SFR_CTRL);
    chk(q[BIT_RDY], 1'b1);
    mv(1'b0, 8'h00);
    chk(q, 8'hA5);
    // Page write of 32 bytes
    wr(SFR_CTRL, 8'h38);
    for (int i = 0; i < 31; i++) begin
      wr(SFR_DPA_LO, 8'h20 + i[7:0]);
      mv(1'b1, i[7:0]);
    end
    rd(SFR_CTRL);
    chk(q[BIT_RDY], 1'b1);
    wr(SFR_CTRL, 8'h18);
    wr(SFR_DPA_LO, 8'h3F);
    mv(1'b1, 8'h1F);
    wait_rdy();
    for (int i = 0; i < 32; i++) begin
      wr(SFR_DPA_LO, 8'h20 + i[7:0]);
      mv(1'b0, 8'h00);
      chk(q, i[7:0]);
    end
    // Low supply refuses and aborts
    supply_low = 1'b1;
    rd(SFR_CTRL);
    chk(q, 8'h1A);
    wr(SFR_DPA_LO, 8'h10);
    mv(1'b1, 8'h77);
    rd(SFR_CTRL);
    chk(q[BIT_RDY], 1'b1);
    mv(1'b0, 8'h00);
    chk(q, 8'hA5);
    supply_low = 1'b0;
    mv(1'b1, 8'h66);
    repeat (4) @(posedge core_clk);
    #1 supply_low = 1'b1;
    rd(SFR_CTRL);
    rd(SFR_CTRL);
    chk(q[BIT_RDY], 1'b1);
    mv(1'b0, 8'h00);
    chk(q, 8'hA5);
    // Reset in mid-run
    supply_low = 1'b0;
    resetn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    chk({xdone, ext_sel, ext_addr}, 18'h00000);
    chk(xrdata, 8'h00);
    rd(SFR_CTRL);
    chk(q, CTRL_RESET);
    rd(SFR_DPA_LO);
    chk(q, 8'h00);
    stop_test();
  end
endmodule
